// file: core/program_counter_and_call_stack.sv
/*
 Program counter with software low byte, high latch and return stack.
 Assumes the execution logic asserts at most one control strobe per
 cycle, and that all strobes come from logic on sys_clk.
*/
`timescale 1ns/1ns
module program_counter_and_call_stack
   import pc_stack_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // Sequencing
   input wire logic advance,
   // Software access to low byte and latch
   input wire logic low_byte_write,
   input wire logic add_to_register_op,
   input wire logic [LOW_W-1:0] low_byte_data,
   input wire logic latch_write,
   input wire logic [LOW_W-1:0] latch_data,
   // Branches
   input wire logic goto_op,
   input wire logic call_op,
   input wire logic [JUMP_W-1:0] jump_target,
   input wire logic interrupt_entry,
   // Returns
   input wire logic return_op,
   input wire logic return_with_literal_op,
   input wire logic return_from_interrupt_op,
   // State seen by the core
   output logic [PC_W-1:0] pc,
   output logic [LOW_W-1:0] pc_low_byte_reg,
   output logic [LOW_W-1:0] pc_high_latch,
   output logic pop_pending
);
   logic [PC_W-1:0] next_pc;
   logic [UP_W-1:0] pc_upper_bits;
   logic [PTR_W-1:0] sp;
   logic [PTR_W-1:0] sp_top;
   logic [PC_W-1:0] stack_rd;
   logic [PC_W-1:0] ret_addr;
   logic [PC_W-1:0] push_data;
   logic do_push;
   logic do_pop;
   logic any_ret;
   logic [LOW_W-1:0] sum_low;
   stack_op_e op;
   stack_op_e next_op;

   function automatic logic [PC_W-1:0] paged(
      input logic [LOW_W-1:0] latch,
      input logic [JUMP_W-1:0] tgt
   );
      paged = {latch[UP_W-1:UP_W-PAGE_W], tgt};
   endfunction

   assign pc_upper_bits = pc[PC_W-1:LOW_W];
   assign ret_addr = pc + PC_ONE;
   assign any_ret = return_op | return_with_literal_op |
                    return_from_interrupt_op;
   assign do_push = call_op | interrupt_entry;
   // Interrupt saves pc itself; it already names the next instruction
   assign push_data = interrupt_entry ? pc : ret_addr;
   assign do_pop = any_ret;
   // Add wraps within the byte; upper bits come from the latch
   assign sum_low = pc_low_byte_reg + low_byte_data;

   // Popped address arrives one cycle late from the registered store
   assign next_op = do_pop ? ST_POP : do_push ? ST_PUSH : ST_RUN;

   always_comb begin
      next_pc = pc;
      case (op)
         ST_POP: next_pc = stack_rd;
         default: begin
            if (interrupt_entry) begin
               next_pc = INT_VECTOR;
            end else if (call_op || goto_op) begin
               next_pc = paged(pc_high_latch, jump_target);
            end else if (add_to_register_op) begin
               next_pc = {pc_high_latch[UP_W-1:0], sum_low};
            end else if (low_byte_write) begin
               next_pc = {pc_high_latch[UP_W-1:0], low_byte_data};
            end else if (advance && !do_pop) begin
               next_pc = ret_addr;
            end
         end
      endcase
   end

   stack_pointer u_sp (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .push(do_push),
      .pop(do_pop),
      .ptr(sp),
      .top(sp_top)
   );

   // Pointer lives only in u_sp; no software path reaches it
   return_stack_ram u_ram (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .wr_en(do_push),
      .wr_addr(sp),
      .wr_data(push_data),
      .rd_addr(sp_top),
      .rd_data(stack_rd)
   );

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pc <= PC_RESET;
         op <= ST_RUN;
      end else begin
         pc <= next_pc;
         op <= next_op;
      end
   end

   // Latch is touched only by software writes
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pc_high_latch <= 8'h00;
      end else if (latch_write) begin
         pc_high_latch <= latch_data;
      end
   end

   // Low byte is also exposed on its own; upper bits are seen only through the full pc port
   assign pc_low_byte_reg = pc[LOW_W-1:0];
   assign pop_pending = op == ST_POP;

   // No overflow flag exists by design

   a_reset_upper_clear: assert property (
      @(posedge sys_clk) $rose(reset_n) |-> pc_upper_bits == UP_RESET
   ) else $error("upper bits not clear after reset");

   a_low_write_load: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (low_byte_write && !add_to_register_op && !call_op && !goto_op &&
       !interrupt_entry && op != ST_POP)
      |=> pc == {$past(pc_high_latch[UP_W-1:0]), $past(low_byte_data)}
   ) else $error("low byte write did not load pc");

   a_call_page_sel: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      ((call_op || goto_op) && !interrupt_entry && op != ST_POP)
      |=> pc[PC_W-1:JUMP_W] == $past(pc_high_latch[UP_W-1:UP_W-PAGE_W])
   ) else $error("page bits wrong on branch");

   a_branch_low_bits: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      ((call_op || goto_op) && !interrupt_entry && op != ST_POP)
      |=> pc[JUMP_W-1:0] == $past(jump_target)
   ) else $error("branch target bits wrong");

   a_call_return_pair: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (call_op && !interrupt_entry && op != ST_POP) ##1
      (return_op && !call_op && !interrupt_entry)
      |=> ##1 pc == $past(pc, 3) + PC_ONE
   ) else $error("return did not restore caller");

   a_push_moves_ptr: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      do_push |=> sp == $past(sp) + PTR_ONE
   ) else $error("push did not advance pointer");

   a_pop_wraps_ptr: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (do_pop && !do_push && sp == PTR_RESET) |=> sp == 3'h7
   ) else $error("pop did not wrap pointer");

   a_latch_kept_ops: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      ((do_push || do_pop) && !latch_write) |=> $stable(pc_high_latch)
   ) else $error("stack op changed latch");

   a_add_no_carry: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (add_to_register_op && !call_op && !goto_op && !interrupt_entry &&
       op != ST_POP)
      |=> pc[PC_W-1:LOW_W] == $past(pc_high_latch[UP_W-1:0])
   ) else $error("computed jump carried upward");

   a_add_low_sum: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (add_to_register_op && !call_op && !goto_op && !interrupt_entry &&
       op != ST_POP)
      |=> pc[LOW_W-1:0] == $past(pc_low_byte_reg) + $past(low_byte_data)
   ) else $error("computed jump sum wrong");

   a_int_vector_load: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (interrupt_entry && op != ST_POP) |=> pc == INT_VECTOR
   ) else $error("interrupt did not load vector");

   a_push_stores_ret: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      do_push |=> u_ram.mem[sp - PTR_ONE] == $past(push_data)
   ) else $error("push did not store return address");

   a_pop_loads_top: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      op == ST_POP |=> pc == $past(stack_rd)
   ) else $error("pop did not load stack top");

   a_ret_sets_pending: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      do_pop |=> pop_pending
   ) else $error("return did not raise pending");

   a_pending_clears: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (pop_pending && !do_pop) |=> !pop_pending
   ) else $error("pending stuck high");

   // Return strobe must not let pc step before the popped value lands
   a_ret_holds_pc: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (do_pop && op != ST_POP && !do_push && !goto_op &&
       !add_to_register_op && !low_byte_write)
      |=> $stable(pc)
   ) else $error("pc moved during return");

   a_advance_step: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (advance && op != ST_POP && !do_pop && !do_push && !goto_op &&
       !add_to_register_op && !low_byte_write)
      |=> pc == $past(pc) + PC_ONE
   ) else $error("advance did not step pc");

   a_latch_write_load: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      latch_write |=> pc_high_latch == $past(latch_data)
   ) else $error("latch write lost");

   a_latch_hold: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      !latch_write |=> $stable(pc_high_latch)
   ) else $error("latch changed without write");

   a_pop_moves_ptr: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (do_pop && !do_push) |=> sp == $past(sp) - PTR_ONE
   ) else $error("pop did not retreat pointer");

   a_ptr_idle_hold: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (!do_push && !do_pop) |=> $stable(sp)
   ) else $error("pointer moved while idle");

   a_wrap_push_ptr: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (do_push && sp == 3'h7) |=> sp == PTR_RESET
   ) else $error("push did not wrap pointer");

   a_reset_ptr_clear: assert property (
      @(posedge sys_clk) $rose(reset_n) |-> sp == PTR_RESET
   ) else $error("pointer not clear after reset");

   a_goto_no_push: assert property (
      @(posedge sys_clk) disable iff (!reset_n)
      (goto_op && !call_op && !interrupt_entry && !do_pop)
      |=> $stable(sp)
   ) else $error("goto moved the stack");

   c_call_seen: cover property (@(posedge sys_clk) call_op);
   c_return_seen: cover property (@(posedge sys_clk) op == ST_POP);
   c_wrap_push: cover property (
      @(posedge sys_clk) do_push && sp == 3'h7);
   c_int_entry: cover property (@(posedge sys_clk) interrupt_entry);
   c_pop_wrap: cover property (
      @(posedge sys_clk) do_pop && sp == PTR_RESET);
endmodule

// file: core/pc_stack_pkg.sv
/*
 Constants for the program counter and return-address stack.
 Assumes a single core clock and an active-low asynchronous reset.
*/
package pc_stack_pkg;
   localparam int PC_W = 13;
   localparam int LOW_W = 8;
   localparam int UP_W = 5;
   localparam int JUMP_W = 11;
   localparam int PAGE_W = 2;
   localparam int DEPTH = 8;
   localparam int PTR_W = 3;
   localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
   localparam logic [PTR_W-1:0] PTR_RESET = 3'h0;
   localparam logic [PTR_W-1:0] PTR_ONE = 3'h1;
   localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
   localparam logic [UP_W-1:0] UP_RESET = 5'h00;
   localparam logic [PC_W-1:0] INT_VECTOR = 13'h0004;

   typedef enum logic [2:0] {
      ST_RUN = 3'b001,
      ST_PUSH = 3'b010,
      ST_POP = 3'b100
   } stack_op_e;
endpackage

// file: core/return_stack_ram.sv
/*
 Eight-entry return-address store with registered read data.
 Assumes the caller supplies a valid pointer each cycle.
*/
`timescale 1ns/1ns
module return_stack_ram
   import pc_stack_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // Write side
   input wire logic wr_en,
   input wire logic [PTR_W-1:0] wr_addr,
   input wire logic [PC_W-1:0] wr_data,
   // Read side
   input wire logic [PTR_W-1:0] rd_addr,
   output logic [PC_W-1:0] rd_data
);
   logic [PC_W-1:0] mem [DEPTH];

   // Storage has no reset; contents after reset are undefined
   always_ff @(posedge sys_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_data <= PC_RESET;
      end else begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule

// file: core/stack_pointer.sv
/*
 Circular three-bit stack pointer.
 Assumes push and pop are never requested together.
*/
`timescale 1ns/1ns
module stack_pointer
   import pc_stack_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // Operations
   input wire logic push,
   input wire logic pop,
   // Pointer to next free slot and to top entry
   output logic [PTR_W-1:0] ptr,
   output logic [PTR_W-1:0] top
);
   logic [PTR_W-1:0] next_ptr;

   // Natural 3-bit overflow gives circular wrap both ways
   assign next_ptr = push ? ptr + PTR_ONE :
                     pop ? ptr - PTR_ONE : ptr;
   assign top = ptr - PTR_ONE;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         ptr <= PTR_RESET;
      end else begin
         ptr <= next_ptr;
      end
   end
endmodule

// file: dv/exec_model.sv
/*
 Execution-side model: turns a bench op code into one control strobe.
 Assumes the bench changes the op code just after sys_clk rises.
*/
`timescale 1ns/1ns
module exec_model (
   // Op select from the bench
   input wire logic [3:0] op,
   // Strobes to the counter
   output logic low_byte_write,
   output logic add_to_register_op,
   output logic latch_write,
   output logic goto_op,
   output logic call_op,
   output logic interrupt_entry,
   output logic return_op,
   output logic return_with_literal_op,
   output logic return_from_interrupt_op
);
   // One-hot decode, so two strobes can never meet in a cycle
   assign low_byte_write = op == 4'h1;
   assign add_to_register_op = op == 4'h2;
   assign latch_write = op == 4'h3;
   assign goto_op = op == 4'h4;
   assign call_op = op == 4'h5;
   assign interrupt_entry = op == 4'h6;
   assign return_op = op == 4'h7;
   assign return_with_literal_op = op == 4'h8;
   assign return_from_interrupt_op = op == 4'h9;
endmodule

// file: dv/testbench.sv
/*
 Directed bench for the program counter and return stack.
 Assumes exec_model turns op codes into strobes combinationally.
*/
`timescale 1ns/1ns
module testbench;
   import pc_stack_pkg::*;
   logic sys_clk, lw, ad, lt, gt, cl, ie, rt, rl, rf;
   logic advance = 1'b0;
   logic reset_n = 1'b0;
   logic [3:0] op = 4'h0;
   logic [7:0] low_byte_data = 8'h00;
   logic [7:0] latch_data = 8'h00;
   logic [10:0] jump_target = 11'h000;
   logic [12:0] pc;
   logic [7:0] pc_low_byte_reg, pc_high_latch;
   logic pop_pending;
   int n_fail = 0;
   int total_checks = 0;
   int cycles = 0;
   exec_model model (.op(op), .low_byte_write(lw), .add_to_register_op(ad),
      .latch_write(lt), .goto_op(gt), .call_op(cl), .interrupt_entry(ie),
      .return_op(rt), .return_with_literal_op(rl),
      .return_from_interrupt_op(rf));
   program_counter_and_call_stack uut (.sys_clk(sys_clk),
      .reset_n(reset_n), .advance(advance), .low_byte_write(lw),
      .add_to_register_op(ad), .low_byte_data(low_byte_data),
      .latch_write(lt), .latch_data(latch_data), .goto_op(gt),
      .call_op(cl), .jump_target(jump_target), .interrupt_entry(ie),
      .return_op(rt), .return_with_literal_op(rl),
      .return_from_interrupt_op(rf), .pc(pc),
      .pc_low_byte_reg(pc_low_byte_reg), .pc_high_latch(pc_high_latch),
      .pop_pending(pop_pending));
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   // Run needs about 60 cycles; generous ceiling
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 500) begin
         n_fail++;
         end_sim();
      end
   end
   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [12:0] e, g);
      total_checks++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic issue(input logic [3:0] code, input logic [10:0] t);
      @(posedge sys_clk);
      op <= code;
      jump_target <= t;
   endtask
   task automatic settle(input int n);
      repeat (n) begin
         @(posedge sys_clk);
         op <= 4'h0;
      end
      #1;
   endtask
   task automatic t_reset;
      reset_n <= 1'b0;
      settle(2);
      chk("pc", 13'h0000, pc);
      chk("latch", 13'h0000, {5'h00, pc_high_latch});
      reset_n <= 1'b1;
   endtask
   task automatic t_low_add_goto;
      latch_data <= 8'h1A;
      low_byte_data <= 8'h34;
      issue(4'h3, 11'h000);
      issue(4'h1, 11'h000);
      settle(1);
      chk("pc low write", 13'h1A34, pc);
      chk("low byte", 13'h0034, {5'h00, pc_low_byte_reg});
      low_byte_data <= 8'hF0;
      issue(4'h2, 11'h000);
      settle(1);
      chk("pc add", 13'h1A24, pc);
      issue(4'h4, 11'h5A5);
      settle(1);
      chk("pc goto", 13'h1DA5, pc);
   endtask
   task automatic t_call_ret;
      issue(4'h5, 11'h123);
      issue(4'h7, 11'h000);
      settle(1);
      chk("pending", 13'h0001, {12'h000, pop_pending});
      settle(1);
      chk("pc return", 13'h1DA6, pc);
      chk("pending off", 13'h0000, {12'h000, pop_pending});
      chk("latch", 13'h001A, {5'h00, pc_high_latch});
   endtask
   task automatic t_circular;
      int idx;
      for (int i = 0; i < 9; i++) issue(4'h5, 11'(i * 16 + 1));
      settle(1);
      chk("pc ninth call", {2'b11, 11'h081}, pc);
      // Ninth push overwrote the first; ninth pop wraps round
      for (int k = 0; k < 9; k++) begin
         idx = (k == 8) ? 8 : 8 - k;
         issue(4'(7 + k % 3), 11'h000);
         settle(2);
         chk("pc pop", {2'b11, 11'(idx * 16 - 14)}, pc);
      end
   endtask
   task automatic t_int_adv;
      issue(4'h6, 11'h000);
      settle(1);
      chk("pc vector", INT_VECTOR, pc);
      issue(4'h9, 11'h000);
      settle(2);
      chk("pc return_from_interrupt_op", 13'h1872, pc);
      advance <= 1'b1;
      settle(3);
      advance <= 1'b0;
      chk("pc advance", 13'h1875, pc);
   endtask
   initial begin
      t_reset();
      t_low_add_goto();
      t_call_ret();
      t_circular();
      t_int_adv();
      t_reset();
      end_sim();
   end
endmodule
